/* rtl/three_wire_serial_channel.sv */
`timescale 1ns/1ps

// Summary of operation
// - Enable bit low stops shifting, clears bit count, releases all three pins.
// - Enable bit high allows shifting and counting and connects serial pins.
// - Direction zero is full duplex; writing the shift register starts a transfer.
// - Direction one is receive-only; reading the shift register starts a transfer.
// - Three-bit selector picks external, timer, or peripheral clock divided 8/16/32/64.
// - Each transfer moves eight bits, one per serial clock cycle.
// - Load shift register MSB into output latch on falling serial clock edge; latch drives data-out pin.
// - Sample data-in on rising serial clock edge into the shift register.
// - After the eighth bit stop automatically and pulse the done request.
// - Start only when enabled and the internal serial clock rests high.
// - A shift register write while disabled never starts a later transfer.
// - Most significant bit always goes and arrives first.
// - Reset clears shift register, mode register and clock select to zero.
// - Selector top bit lives in clock select register, low bits in mode register.
module three_wire_serial_channel #(
   parameter logic [31:0] MODE_CTRL_ADDR = serial_channel_pkg::ADDR_MODE_CTRL_CH0,
   parameter bit          USE_TIMER_B    = 1'b0
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic [31:0] cpu_addr,
   input  wire logic        cpu_wr,
   input  wire logic        cpu_rd,
   input  wire logic [7:0]  cpu_wdata,
   output logic      [7:0]  cpu_rdata,
   input  wire logic        timer_a_output,
   input  wire logic        timer_b_output,
   input  wire logic        serial_clock_pin_in,
   output logic             serial_clock_pin_out,
   output logic             serial_clock_pin_oe,
   input  wire logic        serial_data_in_pin,
   output logic             serial_data_out_pin,
   output logic             serial_data_out_oe,
   output logic             serial_data_in_used,
   output logic             transfer_done_irq,
   output logic             busy
);

   // ********************************************************************
   // State
   // ********************************************************************
   typedef struct packed {
      logic [7:0] shift_register;
      logic [7:0] serial_mode_ctrl;
      logic [7:0] serial_clock_select_reg;
      logic [3:0] bit_count;
      logic       active;
      logic       out_latch;
      logic       int_clk;
      logic [5:0] div_count;
      logic       done;
      logic [7:0] rdata;
   } chan_state_t;

   chan_state_t s;
   chan_state_t next_s;

   logic       ext_level;
   logic       ext_rise;
   logic       ext_fall;
   logic       tmr_level;
   logic       tmr_rise;
   logic       tmr_fall;
   logic       sin_level;
   logic       channel_enable;
   logic       direction_select;
   logic [2:0] clk_code;
   logic [5:0] half_period;
   logic       internal_div;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       hit_shift;
   logic       hit_mode;
   logic       hit_clksel;
   logic       trigger;
   logic       int_source;
   logic       tick;
   logic       fall_ev;
   logic       rise_ev;

   // ********************************************************************
   // Synchronisers for the pins and the timer outputs
   // ********************************************************************
   edge_sync u_sck_sync (
      .clk      (clk),
      .reset    (reset),
      .ce       (ce),
      .async_in (serial_clock_pin_in),
      .level    (ext_level),
      .rise     (ext_rise),
      .fall     (ext_fall)
   );

   edge_sync u_tmr_sync (
      .clk      (clk),
      .reset    (reset),
      .ce       (ce),
      .async_in (USE_TIMER_B ? timer_b_output : timer_a_output),
      .level    (tmr_level),
      .rise     (tmr_rise),
      .fall     (tmr_fall)
   );

   edge_sync u_sin_sync (
      .clk      (clk),
      .reset    (reset),
      .ce       (ce),
      .async_in (serial_data_in_pin),
      .level    (sin_level),
      .rise     (),
      .fall     ()
   );

   // ********************************************************************
   // Decode and clock selection
   // ********************************************************************
   assign channel_enable   = s.serial_mode_ctrl[serial_channel_pkg::BIT_CHANNEL_ENABLE];
   assign direction_select = s.serial_mode_ctrl[serial_channel_pkg::BIT_DIRECTION_SELECT];
   assign clk_code = {s.serial_clock_select_reg[serial_channel_pkg::BIT_CLOCK_SEL2],
                      s.serial_mode_ctrl[serial_channel_pkg::BIT_CLOCK_SEL1],
                      s.serial_mode_ctrl[serial_channel_pkg::BIT_CLOCK_SEL0]};

   assign hit_shift  = cpu_addr == MODE_CTRL_ADDR - serial_channel_pkg::OFS_MODE_CTRL
                                 + serial_channel_pkg::OFS_SHIFT_REG;
   assign hit_mode   = cpu_addr == MODE_CTRL_ADDR;
   assign hit_clksel = cpu_addr == MODE_CTRL_ADDR - serial_channel_pkg::OFS_MODE_CTRL
                                 + serial_channel_pkg::OFS_CLOCK_SELECT;

   always_comb begin
      internal_div = 1'b1;
      int_source   = 1'b1;
      half_period  = serial_channel_pkg::HALF_DIV8;
      sclk_rise    = 1'b0;
      sclk_fall    = 1'b0;
      case (clk_code)
         serial_channel_pkg::CLK_EXTERNAL: begin
            internal_div = 1'b0;
            int_source   = 1'b0;
            sclk_rise    = ext_rise;
            sclk_fall    = ext_fall;
         end
         serial_channel_pkg::CLK_TIMER: begin
            internal_div = 1'b0;
            sclk_rise    = tmr_rise;
            sclk_fall    = tmr_fall;
         end
         serial_channel_pkg::CLK_DIV8:  half_period = serial_channel_pkg::HALF_DIV8;
         serial_channel_pkg::CLK_DIV16: half_period = serial_channel_pkg::HALF_DIV16;
         serial_channel_pkg::CLK_DIV32: half_period = serial_channel_pkg::HALF_DIV32;
         serial_channel_pkg::CLK_DIV64: half_period = serial_channel_pkg::HALF_DIV64;
         default: begin
            // Forbidden codes produce no clock, so a transfer simply waits.
            internal_div = 1'b0;
            int_source   = 1'b0;
         end
      endcase
   end

   // The timer output is gated into a clock of our own that starts with a fall and rests high,
   // so a free-running timer never hands the far side a half cycle at the start of a byte.
   assign tick    = internal_div ? (s.div_count == half_period)
                                 : (int_source & (s.int_clk ? sclk_fall : sclk_rise));
   assign fall_ev = int_source ? (tick & s.int_clk) : sclk_fall;
   assign rise_ev = int_source ? (tick & ~s.int_clk) : sclk_rise;

   // A start needs the internal clock idling high from the previous byte.
   assign trigger = channel_enable & ~s.active & s.int_clk
                  & ((cpu_wr & hit_shift & ~direction_select)
                   | (cpu_rd & hit_shift & direction_select));

   // ********************************************************************
   // Next state
   // ********************************************************************
   always_comb begin
      next_s = s;
      if (ce) begin
         next_s.done = 1'b0;
         if (cpu_rd) begin
            next_s.rdata = 8'h00;
            if (hit_shift) begin
               next_s.rdata = s.shift_register;
            end else if (hit_mode) begin
               next_s.rdata = s.serial_mode_ctrl;
            end else if (hit_clksel) begin
               next_s.rdata = s.serial_clock_select_reg;
            end
         end
         if (cpu_wr && hit_mode) begin
            next_s.serial_mode_ctrl = cpu_wdata & serial_channel_pkg::MODE_CTRL_WMASK;
         end
         if (cpu_wr && hit_clksel) begin
            next_s.serial_clock_select_reg = cpu_wdata & serial_channel_pkg::CLOCK_SELECT_WMASK;
         end
         // Writes land even while disabled, but never arm a transfer.
         if (cpu_wr && hit_shift && !s.active) begin
            next_s.shift_register = cpu_wdata;
         end

         if (!channel_enable) begin
            next_s.active    = 1'b0;
            next_s.bit_count = 4'h0;
            next_s.int_clk   = 1'b1;
            next_s.div_count = 6'h00;
         end else begin
            if (trigger) begin
               next_s.active    = 1'b1;
               next_s.bit_count = 4'h0;
               next_s.div_count = 6'h00;
            end
            if (s.active && internal_div) begin
               next_s.div_count = tick ? 6'h00 : s.div_count + 6'h01;
            end
            if (s.active && tick) begin
               next_s.int_clk = ~s.int_clk;
            end
            if (s.active) begin
               if (fall_ev) begin
                  // Falling edge: present the next MSB on the output latch.
                  next_s.out_latch = s.shift_register[7];
               end
               if (rise_ev) begin
                  next_s.shift_register = {s.shift_register[6:0], sin_level};
                  next_s.bit_count      = s.bit_count + 4'h1;
                  if (s.bit_count == serial_channel_pkg::BITS_PER_BYTE - 4'h1) begin
                     next_s.active = 1'b0;
                     next_s.done   = 1'b1;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '{shift_register: serial_channel_pkg::RESET_VALUE,
                serial_mode_ctrl: serial_channel_pkg::RESET_VALUE,
                serial_clock_select_reg: serial_channel_pkg::RESET_VALUE,
                bit_count: 4'h0, active: 1'b0, out_latch: 1'b1, int_clk: 1'b1,
                div_count: 6'h00, done: 1'b0, rdata: 8'h00};
      end else begin
         s <= next_s;
      end
   end

   // ********************************************************************
   // Outputs
   // ********************************************************************
   assign cpu_rdata            = s.rdata;
   assign serial_clock_pin_out = s.int_clk;
   assign serial_clock_pin_oe  = channel_enable & int_source;
   assign serial_data_out_pin  = s.out_latch;
   assign serial_data_out_oe   = channel_enable & ~direction_select;
   assign serial_data_in_used  = channel_enable;
   assign transfer_done_irq    = s.done;
   assign busy                 = s.active;

endmodule : three_wire_serial_channel

/* rtl/serial_channel_pkg.sv */
package serial_channel_pkg;

   // ********************************************************************
   // Register map and fields
   // ********************************************************************
   localparam logic [31:0] ADDR_MODE_CTRL_CH0 = 32'hFFFFF2A2;
   localparam logic [31:0] ADDR_MODE_CTRL_CH1 = 32'hFFFFF2B2;
   localparam logic [31:0] ADDR_MODE_CTRL_CH2 = 32'hFFFFF2C2;
   localparam logic [31:0] ADDR_MODE_CTRL_CH3 = 32'hFFFFF2D2;
   // Shift register and clock select sit beside the mode register.
   localparam logic [31:0] OFS_SHIFT_REG       = 32'h00000000;
   localparam logic [31:0] OFS_MODE_CTRL       = 32'h00000002;
   localparam logic [31:0] OFS_CLOCK_SELECT    = 32'h00000004;

   localparam int          BIT_CHANNEL_ENABLE   = 7;
   localparam int          BIT_DIRECTION_SELECT = 2;
   localparam int          BIT_CLOCK_SEL1       = 1;
   localparam int          BIT_CLOCK_SEL0       = 0;
   localparam int          BIT_CLOCK_SEL2       = 0;
   localparam logic [7:0]  MODE_CTRL_WMASK      = 8'h87;
   localparam logic [7:0]  CLOCK_SELECT_WMASK   = 8'h01;
   localparam logic [7:0]  RESET_VALUE          = 8'h00;

   // ********************************************************************
   // Clock selector codes and divider counts
   // ********************************************************************
   localparam logic [2:0]  CLK_EXTERNAL = 3'h0;
   localparam logic [2:0]  CLK_TIMER    = 3'h1;
   localparam logic [2:0]  CLK_DIV8     = 3'h2;
   localparam logic [2:0]  CLK_DIV16    = 3'h3;
   localparam logic [2:0]  CLK_DIV32    = 3'h6;
   localparam logic [2:0]  CLK_DIV64    = 3'h7;
   localparam logic [5:0]  HALF_DIV8    = 6'h03;
   localparam logic [5:0]  HALF_DIV16   = 6'h07;
   localparam logic [5:0]  HALF_DIV32   = 6'h0F;
   localparam logic [5:0]  HALF_DIV64   = 6'h1F;

   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

endpackage : serial_channel_pkg

/* rtl/edge_sync.sv */
`timescale 1ns/1ps

// Two-stage synchroniser with edge detection taken from the settled stage.
module edge_sync (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic ce,
   input  wire logic async_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   always_comb begin
      next_s = s;
      if (ce) begin
         next_s.meta = async_in;
         next_s.sync = s.meta;
         next_s.prev = s.sync;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '{meta: 1'b1, sync: 1'b1, prev: 1'b1};
      end else begin
         s <= next_s;
      end
   end

   assign level = s.sync;
   assign rise  = s.sync & ~s.prev;
   assign fall  = ~s.sync & s.prev;

endmodule : edge_sync

/* dv/three_wire_serial_channel_properties.sv */
`timescale 1ns/1ps

// ************************************************************
// Port checks for one serial channel
// ************************************************************
module serial_channel_checker #(
   parameter logic [31:0] MODE_CTRL_ADDR = serial_channel_pkg::ADDR_MODE_CTRL_CH0
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [31:0] cpu_addr,
   input  wire logic        cpu_wr,
   input  wire logic        cpu_rd,
   input  wire logic [7:0]  cpu_wdata,
   input  wire logic [7:0]  cpu_rdata,
   input  wire logic        serial_clock_pin_out,
   input  wire logic        serial_clock_pin_oe,
   input  wire logic        serial_data_out_oe,
   input  wire logic        serial_data_in_used,
   input  wire logic        transfer_done_irq,
   input  wire logic        busy
);
   logic [3:0] falls;
   logic       at_shift;
   logic       mapped;
   assign at_shift = cpu_addr == MODE_CTRL_ADDR - 32'h2;
   assign mapped   = at_shift || cpu_addr == MODE_CTRL_ADDR || cpu_addr == MODE_CTRL_ADDR + 32'h2;
   // Counting falls rather than rises keeps the last rise, which ends the byte, out of the race.
   always_ff @(posedge clk) begin
      if (reset || !busy) begin
         falls <= 4'h0;
      end else if ($fell(serial_clock_pin_out)) begin
         falls <= falls + 4'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_mode_write; cpu_wr && cpu_addr == MODE_CTRL_ADDR && !busy; endsequence
   sequence s_mode_read; cpu_rd && cpu_addr == MODE_CTRL_ADDR; endsequence
   sequence s_done; transfer_done_irq ##1 !transfer_done_irq; endsequence
   a_mode_readback: assert property (s_mode_write ##2 s_mode_read |=> cpu_rdata == ($past(cpu_wdata, 3) & 8'h87))
      else $error("mode readback differs");
   a_unmapped_zero: assert property (cpu_rd && !mapped |=> cpu_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_duplex_start: assert property (cpu_wr && at_shift && serial_data_out_oe && !busy |=> busy)
      else $error("write did not start");
   a_rx_start: assert property (cpu_rd && at_shift && serial_data_in_used && !serial_data_out_oe && !busy |=> busy)
      else $error("read did not start");
   a_idle_released: assert property (!serial_data_in_used |-> !busy && !serial_clock_pin_oe && !serial_data_out_oe)
      else $error("disabled channel active");
   a_clock_high: assert property (!busy |-> serial_clock_pin_out)
      else $error("clock not high at rest");
   a_eight_falls: assert property ($fell(busy) && $past(serial_clock_pin_oe) |-> falls == 4'h8)
      else $error("clock cycle count wrong");
   a_done_pulse: assert property ($fell(busy) |-> ##[0:2] s_done)
      else $error("done pulse missing");
   a_busy_bounded: assert property ($rose(busy) |-> ##[60:700] !busy)
      else $error("transfer did not stop");
endmodule : serial_channel_checker

bind three_wire_serial_channel serial_channel_checker #(.MODE_CTRL_ADDR(MODE_CTRL_ADDR)) chk (
   .clk, .reset, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .serial_clock_pin_out,
   .serial_clock_pin_oe, .serial_data_out_oe, .serial_data_in_used, .transfer_done_irq, .busy);

/* dv/serial_peer_model.sv */
`timescale 1ns/1ps

// ************************************************************
// Clocked serial peripheral on the far side
// ************************************************************
module serial_peer_model (
   input  wire logic       sck_in,
   input  wire logic       sck_oe,
   input  wire logic       sdo,
   input  wire logic [7:0] tx_byte,
   input  wire logic       ext_go,
   output logic            sck_line,
   output logic            sdi,
   output logic [7:0]      rx_byte
);
   logic       sck_ext = 1'b1;
   logic [7:0] tx_sh;
   initial sdi = 1'b0;
   assign sck_line = sck_oe ? sck_in : sck_ext;
   // A fresh byte flips the idle line so a stale level never passes for data.
   always @(tx_byte) begin
      tx_sh = tx_byte;
      sdi   = ~sdi;
   end
   always @(negedge sck_line) begin
      sdi   <= tx_sh[7];
      tx_sh <= {tx_sh[6:0], 1'b0};
   end
   always @(posedge sck_line) rx_byte <= {rx_byte[6:0], sdo};
   // Eight high-idle link cycles, phase unrelated to the system clock.
   always @(posedge ext_go) begin
      #233;
      repeat (8) begin
         #400 sck_ext = 1'b0;
         #400 sck_ext = 1'b1;
      end
   end
endmodule : serial_peer_model

/* dv/test_three_wire_serial_channel.sv */
`timescale 1ns/1ps

module test_three_wire_serial_channel;
   localparam logic [31:0] MODE  = serial_channel_pkg::ADDR_MODE_CTRL_CH0;
   localparam logic [31:0] SHIFT = MODE - 32'h2;
   localparam logic [31:0] CSEL  = MODE + 32'h2;
   logic        clk = 1'b0, reset = 1'b1, timer_a = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0, ext_go = 1'b0;
   logic [31:0] cpu_addr = 32'h0;
   logic [7:0]  cpu_wdata = 8'h00, cpu_rdata, tx_byte = 8'h00, rx_byte, v;
   logic        sck_out, sck_oe, sck_line, sdo, sdo_oe, sdi, in_used, irq, busy;
   int          bad_count = 0, samples_checked = 0, cycles = 0, irqs = 0;
   always #50 clk = ~clk;
   always #800 timer_a = ~timer_a;
   always @(posedge clk) begin
      cycles++;
      if (irq === 1'b1) irqs++;
      if (cycles == 20000) begin
         bad_count++;
         test_done();
      end
   end
   three_wire_serial_channel uut (.clk(clk), .reset(reset), .ce(1'b1), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
      .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .timer_a_output(timer_a),
      .timer_b_output(1'b0), .serial_clock_pin_in(sck_line), .serial_clock_pin_out(sck_out),
      .serial_clock_pin_oe(sck_oe), .serial_data_in_pin(sdi), .serial_data_out_pin(sdo),
      .serial_data_out_oe(sdo_oe), .serial_data_in_used(in_used), .transfer_done_irq(irq), .busy(busy));
   serial_peer_model peer (.sck_in(sck_out), .sck_oe(sck_oe), .sdo(sdo), .tx_byte(tx_byte), .ext_go(ext_go),
      .sck_line(sck_line), .sdi(sdi), .rx_byte(rx_byte));
   // ************************************************************
   // Bus cycles and comparison
   // ************************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      cpu_addr  = a;
      cpu_wdata = d;
      cpu_wr    = 1'b1;
      @(posedge clk) #1;
      cpu_wr = 1'b0;
      // The idle edge keeps two calls from setting one strobe twice in a time step.
      @(posedge clk) #1;
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [7:0] d);
      cpu_addr = a;
      cpu_rd   = 1'b1;
      @(posedge clk) #1;
      cpu_rd = 1'b0;
      d      = cpu_rdata;
      @(posedge clk) #1;
   endtask : rd
   // No shift register access is made until the transfer has ended.
   task automatic wait_idle(output int n);
      n = 0;
      while (busy !== 1'b0 && n < 2000) begin
         @(posedge clk) #1;
         n++;
      end
      if (busy !== 1'b0) bad_count++;
   endtask : wait_idle
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset_values();
      rd(MODE, v);
      check(v, 8'h00);
      rd(CSEL, v);
      check(v, 8'h00);
      rd(SHIFT, v);
      check(v, 8'h00);
      rd(MODE + 32'h8, v);
      check(v, 8'h00);
      check({4'h0, sck_oe, sdo_oe, busy, sck_out}, 8'h01);
   endtask : t_reset_values
   task automatic t_disabled_write();
      wr(SHIFT, 8'h5A);
      wr(MODE, 8'h80);
      repeat (20) @(posedge clk);
      #1 check({7'h0, busy}, 8'h00);
      wr(MODE, 8'h00);
   endtask : t_disabled_write
   task automatic t_duplex(input logic [2:0] code, input int div, input logic [7:0] data);
      int n;
      int i0;
      tx_byte = ~data;
      wr(CSEL, {7'h0, code[2]});
      wr(MODE, {1'b1, 5'h0, code[1:0]});
      rd(MODE, v);
      check(v, {1'b1, 5'h0, code[1:0]});
      rd(CSEL, v);
      check(v, {7'h0, code[2]});
      i0 = irqs;
      wr(SHIFT, data);
      wait_idle(n);
      check(rx_byte, data);
      rd(SHIFT, v);
      check(v, ~data);
      check(8'(irqs - i0), 8'h01);
      if (div > 0) check(8'((n + 1) / div), 8'h08);
   endtask : t_duplex
   task automatic t_receive_external();
      int n;
      tx_byte = 8'h3C;
      wr(CSEL, 8'h00);
      wr(MODE, 8'h84);
      rd(SHIFT, v);
      check({6'h0, busy, sdo_oe}, 8'h02);
      ext_go = 1'b1;
      wait_idle(n);
      ext_go = 1'b0;
      rd(SHIFT, v);
      check(v, 8'h3C);
      tx_byte = 8'hE1;
      #1 ext_go = 1'b1;
      wait_idle(n);
      ext_go = 1'b0;
      wr(MODE, 8'h80);
      rd(SHIFT, v);
      check(v, 8'hE1);
      check({7'h0, busy}, 8'h00);
   endtask : t_receive_external
   task automatic test_done();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (16) @(posedge clk);
      #1 reset = 1'b0;
      t_reset_values();
      t_disabled_write();
      t_duplex(3'h1, 0, 8'hA5);
      t_duplex(3'h2, 8, 8'h81);
      t_duplex(3'h3, 16, 8'h4E);
      t_duplex(3'h6, 32, 8'hF0);
      t_duplex(3'h7, 64, 8'h17);
      t_receive_external();
      test_done();
   end
endmodule : test_three_wire_serial_channel
